//--- logic/evlc_core.sv
// How it works
// - loop branch with displacement -4 enters loop mode
// - only single-word, non-flow-changing instructions may be looped
// - in loop mode instruction fetches are suppressed, data cycles remain
// - after each loop pass, condition and counter decide continuation
// - any exception taken ends loop mode and resumes fetching
// - vector table is 256 long words, 1024 bytes at vector base
// - vector number is 8 bits, external or internally generated
// - vector address is base plus vector number times four
// - exception steps: copy status, get vector, save, load context
// - frame holds status register and program counter at exception
// - frame also holds vector offset and a format code
// - return from exception pops words chosen by format code
// - access fault saves small state, later refetches and restarts instruction
// - unimplemented opcodes and illegal modes take an emulation trap
// - bit field, module, dual swap, coprocessor, bcd opcodes are unimplemented
// - low power stop halts processor and signals intermodule bus shutdown
// - stopped until interrupt above chosen priority or at level 7, or reset
// - data sizes byte word long; address registers word and long only
// - eight data and seven address registers plus pc and stack pointers
`timescale 1ns/1ps
`default_nettype none
module evlc_core (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_n_i,
    input  wire logic [15:0]            op_i,
    input  wire logic                   op_valid_i,
    input  wire logic [15:0]            disp_i,
    input  wire logic                   op_is_areg_i,
    input  wire evlc_pkg::evlc_size_t   size_i,
    input  wire logic                   cond_true_i,
    input  wire logic [15:0]            loop_cnt_i,
    input  wire logic                   pass_done_i,
    input  wire logic                   irq_req_i,
    input  wire logic [2:0]             irq_level_i,
    input  wire logic [7:0]             irq_vec_i,
    input  wire logic                   irq_vec_valid_i,
    input  wire logic                   fault_i,
    input  wire logic [31:0]            fault_state_i,
    input  wire logic                   vbr_we_i,
    input  wire logic [31:0]            vbr_wdata_i,
    input  wire logic [31:0]            pc_i,
    input  wire logic [15:0]            sr_i,
    input  wire logic [2:0]             stop_level_i,
    input  wire logic                   bus_ack_i,
    input  wire logic [15:0]            bus_rdata_i,
    output logic                        loop_mode_o,
    output logic                        fetch_en_o,
    output logic                        loop_exit_o,
    output logic [31:0]                 resume_pc_o,
    output logic                        exc_active_o,
    output logic [7:0]                  vec_num_o,
    output logic [31:0]                 vec_addr_o,
    output logic [15:0]                 sr_o,
    output logic                        bus_req_o,
    output logic                        bus_we_o,
    output logic [31:0]                 bus_addr_o,
    output logic [15:0]                 bus_wdata_o,
    output logic                        iack_o,
    output logic                        restart_o,
    output logic                        stopped_o,
    output logic                        imb_shutdown_o,
    output logic [31:0]                 vbr_o
);
    import evlc_pkg::*;

    typedef enum logic [3:0] {
        ST_RUN, ST_COPY_SR, ST_GET_VEC, ST_PUSH, ST_FETCH_HI, ST_FETCH_LO,
        ST_RTE_POP, ST_STOP
    } evlc_state_t;

    typedef struct packed {
        evlc_state_t st;
        logic        ext_d1;
        logic        ext_d2;
        logic [2:0]  lvl_d1;
        logic [2:0]  lvl_d2;
        logic        loop_mode;
        logic        fetch_en;
        logic        loop_exit;
        logic [31:0] resume_pc;
        logic [31:0] branch_pc;
        logic        exc_active;
        logic [7:0]  vec_num;
        logic [31:0] vec_addr;
        logic [15:0] sr_copy;
        logic [15:0] sr;
        logic [31:0] exc_pc;
        logic [3:0]  fmt;
        logic [31:0] fault_state;
        logic        bus_req;
        logic        bus_we;
        logic [31:0] bus_addr;
        logic [15:0] bus_wdata;
        logic [2:0]  word_idx;
        logic [2:0]  word_cnt;
        logic        iack;
        logic        restart;
        logic        stopped;
        logic        imb_shutdown;
        logic [31:0] vector_base_reg;
        logic [31:0] ssp;
        logic [2:0]  stop_lvl;
        logic        prev_ok;
    } evlc_reg_t;

    evlc_reg_t r_reg;
    evlc_reg_t r_next;

    logic unimpl;
    logic loopable;
    logic is_loop_branch;
    logic is_low_power_stop_instr;
    logic is_rte;
    logic irq_ok;
    logic [15:0] frame_word;

    evlc_opcheck u_opcheck (
        .op_i             (op_i),
        .op_is_areg_i     (op_is_areg_i),
        .size_i           (size_i),
        .unimpl_o         (unimpl),
        .loopable_o       (loopable),
        .is_loop_branch_o (is_loop_branch),
        .is_low_power_stop_instr_o      (is_low_power_stop_instr),
        .is_rte_o         (is_rte)
    );

    always_comb begin
        case (r_reg.word_idx)
            3'h0:    frame_word = r_reg.sr_copy;
            3'h1:    frame_word = r_reg.exc_pc[31:16];
            3'h2:    frame_word = r_reg.exc_pc[15:0];
            3'h3:    frame_word = {r_reg.fmt, 2'h0, r_reg.vec_num, 2'h0};
            3'h4:    frame_word = r_reg.fault_state[31:16];
            default: frame_word = r_reg.fault_state[15:0];
        endcase
    end

    always_comb begin
        r_next           = r_reg;
        r_next.ext_d1    = irq_req_i;
        r_next.ext_d2    = r_reg.ext_d1;
        r_next.lvl_d1    = irq_level_i;
        r_next.lvl_d2    = r_reg.lvl_d1;
        r_next.loop_exit = 1'b0;
        r_next.restart   = 1'b0;
        r_next.iack      = 1'b0;
        irq_ok           = r_reg.ext_d2 && (r_reg.lvl_d2 > r_reg.sr[10:SR_IPL_LSB]
                           || r_reg.lvl_d2 == 3'h7);
        if (vbr_we_i) begin
            r_next.vector_base_reg = vbr_wdata_i;
        end
        case (r_reg.st)
            ST_RUN: begin
                r_next.sr = sr_i;
                r_next.prev_ok = op_valid_i ? loopable : r_reg.prev_ok;
                if (fault_i || irq_ok || (op_valid_i && unimpl)) begin
                    r_next.loop_mode   = 1'b0;
                    r_next.fetch_en    = 1'b0;
                    r_next.exc_pc      = pc_i;
                    r_next.fault_state = fault_i ? fault_state_i : FAULT_STATE_RST;
                    r_next.fmt         = fault_i ? FMT_FAULT : FMT_NORMAL;
                    r_next.word_cnt    = fault_i ? FRAME_WORDS_FLT : FRAME_WORDS_NORM;
                    r_next.vec_num     = fault_i ? VEC_ACCESS_FAULT
                                       : (irq_ok ? 8'h00 : VEC_LINE_F);
                    r_next.restart     = fault_i;
                    r_next.st          = ST_COPY_SR;
                end else if (op_valid_i && is_low_power_stop_instr) begin
                    r_next.stopped      = 1'b1;
                    r_next.imb_shutdown = 1'b1;
                    r_next.fetch_en     = 1'b0;
                    r_next.stop_lvl     = stop_level_i;
                    r_next.st           = ST_STOP;
                end else if (op_valid_i && is_rte) begin
                    r_next.word_idx = 3'h0;
                    r_next.bus_req  = 1'b1;
                    r_next.bus_we   = 1'b0;
                    r_next.bus_addr = r_reg.ssp + 32'h6;
                    r_next.fetch_en = 1'b0;
                    r_next.st       = ST_RTE_POP;
                end else if (op_valid_i && is_loop_branch && !r_reg.loop_mode) begin
                    if (disp_i == LOOP_DISP && r_reg.prev_ok) begin
                        r_next.loop_mode = 1'b1;
                        r_next.fetch_en  = 1'b0;
                        r_next.branch_pc = pc_i + 32'h2;
                    end
                end else if (r_reg.loop_mode && pass_done_i) begin
                    if (cond_true_i || loop_cnt_i == LOOP_CNT_EXPIRED) begin
                        r_next.loop_mode = 1'b0;
                        r_next.fetch_en  = 1'b1;
                        r_next.loop_exit = 1'b1;
                        r_next.resume_pc = r_reg.branch_pc + 32'h2;
                    end
                end
            end
            ST_COPY_SR: begin
                r_next.sr_copy    = r_reg.sr;
                r_next.sr         = (r_reg.sr & SR_TRACE_MASK) | SR_SUPER_BIT;
                r_next.exc_active = 1'b1;
                r_next.st         = ST_GET_VEC;
                if (r_reg.vec_num == 8'h00) begin
                    r_next.iack = 1'b1;
                end
            end
            ST_GET_VEC: begin
                if (r_reg.vec_num != 8'h00 || irq_vec_valid_i) begin
                    if (r_reg.vec_num == 8'h00) begin
                        r_next.vec_num = irq_vec_i;
                        r_next.sr[10:SR_IPL_LSB] = r_reg.lvl_d2;
                    end
                    r_next.word_idx = 3'h0;
                    r_next.st       = ST_PUSH;
                end
            end
            ST_PUSH: begin
                r_next.vec_addr  = r_reg.vector_base_reg + {22'h0, r_reg.vec_num, 2'h0};
                r_next.bus_req   = 1'b1;
                r_next.bus_we    = 1'b1;
                r_next.bus_addr  = r_reg.ssp - {28'h0, r_reg.word_cnt, 1'b0}
                                   + {28'h0, r_reg.word_idx, 1'b0};
                r_next.bus_wdata = frame_word;
                if (r_reg.bus_req && bus_ack_i) begin
                    r_next.bus_req  = 1'b0;
                    r_next.word_idx = r_reg.word_idx + 3'h1;
                    if (r_reg.word_idx + 3'h1 == r_reg.word_cnt) begin
                        r_next.ssp      = r_reg.ssp - {28'h0, r_reg.word_cnt, 1'b0};
                        r_next.bus_addr = r_next.vec_addr;
                        r_next.bus_we   = 1'b0;
                        r_next.bus_req  = 1'b1;
                        r_next.st       = ST_FETCH_HI;
                    end
                end
            end
            ST_FETCH_HI: begin
                if (bus_ack_i) begin
                    r_next.resume_pc[31:16] = bus_rdata_i;
                    r_next.bus_addr         = r_reg.bus_addr + 32'h2;
                    r_next.st               = ST_FETCH_LO;
                end
            end
            ST_FETCH_LO: begin
                if (bus_ack_i) begin
                    r_next.resume_pc[15:0] = bus_rdata_i;
                    r_next.bus_req         = 1'b0;
                    r_next.exc_active      = 1'b0;
                    r_next.fetch_en        = 1'b1;
                    r_next.st              = ST_RUN;
                end
            end
            ST_RTE_POP: begin
                if (bus_ack_i) begin
                    r_next.bus_req = 1'b0;
                    if (bus_rdata_i[15:12] == FMT_FAULT) begin
                        r_next.ssp     = r_reg.ssp + {28'h0, FRAME_WORDS_FLT, 1'b0};
                        r_next.restart = 1'b1;
                    end else if (bus_rdata_i[15:12] == FMT_NORMAL) begin
                        r_next.ssp = r_reg.ssp + {28'h0, FRAME_WORDS_NORM, 1'b0};
                    end else begin
                        r_next.vec_num  = VEC_FORMAT_ERR;
                        r_next.fmt      = FMT_NORMAL;
                        r_next.word_cnt = FRAME_WORDS_NORM;
                        r_next.exc_pc   = pc_i;
                        r_next.st       = ST_COPY_SR;
                    end
                    if (bus_rdata_i[15:12] == FMT_FAULT
                        || bus_rdata_i[15:12] == FMT_NORMAL) begin
                        r_next.fetch_en = 1'b1;
                        r_next.st       = ST_RUN;
                    end
                end
            end
            ST_STOP: begin
                if (r_reg.ext_d2 && (r_reg.lvl_d2 > r_reg.stop_lvl
                    || r_reg.lvl_d2 == 3'h7)) begin
                    r_next.stopped      = 1'b0;
                    r_next.imb_shutdown = 1'b0;
                    r_next.vec_num      = 8'h00;
                    r_next.fmt          = FMT_NORMAL;
                    r_next.word_cnt     = FRAME_WORDS_NORM;
                    r_next.exc_pc       = pc_i;
                    r_next.st           = ST_COPY_SR;
                end
            end
            default: r_next.st = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg              <= '0;
            r_reg.st           <= ST_RUN;
            r_reg.fetch_en     <= 1'b1;
            r_reg.sr           <= SR_RESET;
            r_reg.vector_base_reg          <= VBR_RESET;
            r_reg.resume_pc    <= PC_RESET;
            r_reg.stop_lvl     <= IPL_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign loop_mode_o    = r_reg.loop_mode;
    assign fetch_en_o     = r_reg.fetch_en;
    assign loop_exit_o    = r_reg.loop_exit;
    assign resume_pc_o    = r_reg.resume_pc;
    assign exc_active_o   = r_reg.exc_active;
    assign vec_num_o      = r_reg.vec_num;
    assign vec_addr_o     = r_reg.vec_addr;
    assign sr_o           = r_reg.sr;
    assign bus_req_o      = r_reg.bus_req;
    assign bus_we_o       = r_reg.bus_we;
    assign bus_addr_o     = r_reg.bus_addr;
    assign bus_wdata_o    = r_reg.bus_wdata;
    assign iack_o         = r_reg.iack;
    assign restart_o      = r_reg.restart;
    assign stopped_o      = r_reg.stopped;
    assign imb_shutdown_o = r_reg.imb_shutdown;
    assign vbr_o          = r_reg.vector_base_reg;
endmodule // evlc_core
`default_nettype wire

//--- logic/evlc_pkg.sv
package evlc_pkg;

    localparam int          VEC_NUM_W        = 8;
    localparam int          ADDR_W           = 32;
    localparam int          OP_W             = 16;
    localparam int          VEC_TABLE_BYTES  = 1024;
    localparam int          VEC_COUNT        = 256;
    localparam logic [1:0]  VEC_SCALE_SHIFT  = 2'h2;
    localparam logic [15:0] LOOP_DISP        = 16'hFFFC;
    localparam logic [15:0] LOOP_CNT_EXPIRED = 16'hFFFF;
    localparam logic [31:0] VBR_RESET        = 32'h00000000;
    localparam logic [31:0] PC_RESET         = 32'h00000000;
    localparam logic [15:0] SR_RESET         = 16'h2700;
    localparam logic [15:0] SR_SUPER_BIT     = 16'h2000;
    localparam logic [15:0] SR_TRACE_MASK    = 16'h3FFF;
    localparam int          SR_IPL_LSB       = 8;
    localparam logic [2:0]  IPL_RESET        = 3'h7;
    localparam logic [7:0]  VEC_ILLEGAL      = 8'h04;
    localparam logic [7:0]  VEC_FORMAT_ERR   = 8'h0E;
    localparam logic [7:0]  VEC_ACCESS_FAULT = 8'h02;
    localparam logic [7:0]  VEC_LINE_F       = 8'h0B;
    localparam logic [3:0]  FMT_NORMAL       = 4'h0;
    localparam logic [3:0]  FMT_FAULT        = 4'hC;
    localparam logic [2:0]  FRAME_WORDS_NORM = 3'h4;
    localparam logic [2:0]  FRAME_WORDS_FLT  = 3'h6;
    localparam logic [31:0] FAULT_STATE_RST  = 32'h00000000;

    typedef enum logic [1:0] {
        EVLC_SIZE_BYTE,
        EVLC_SIZE_WORD,
        EVLC_SIZE_LONG,
        EVLC_SIZE_BAD
    } evlc_size_t;

endpackage : evlc_pkg

//--- logic/evlc_opcheck.sv
`timescale 1ns/1ps
`default_nettype none
module evlc_opcheck (
    input  wire logic [15:0]        op_i,
    input  wire logic               op_is_areg_i,
    input  wire evlc_pkg::evlc_size_t size_i,
    output logic                    unimpl_o,
    output logic                    loopable_o,
    output logic                    is_loop_branch_o,
    output logic                    is_low_power_stop_instr_o,
    output logic                    is_rte_o
);
    import evlc_pkg::*;

    logic bit_field_ops;
    logic module_call;
    logic dual_compare_and_swap;
    logic coproc;
    logic bcd_expand;
    logic bad_size;

    always_comb begin
        bit_field_ops         = (op_i[15:11] == 5'h1D) && (op_i[7:6] == 2'h3);
        module_call           = (op_i[15:6] == 10'h01B);
        dual_compare_and_swap = (op_i[15:11] == 5'h01) && op_i[9] && (op_i[7:6] == 2'h3);
        coproc                = (op_i[15:12] == 4'hF) && (op_i != 16'hF800);
        bcd_expand            = (op_i[15:12] == 4'h8) && (op_i[8:4] inside {5'h14, 5'h18});
        bad_size              = (size_i == EVLC_SIZE_BAD)
                                || (op_is_areg_i && size_i == EVLC_SIZE_BYTE);
        unimpl_o              = bit_field_ops || module_call || dual_compare_and_swap
                                || coproc || bcd_expand || bad_size;
        is_loop_branch_o      = (op_i[15:12] == 4'h5) && (op_i[7:3] == 5'h19);
        is_low_power_stop_instr_o           = (op_i == 16'hF800);
        is_rte_o              = (op_i == 16'h4E73);
        loopable_o            = !unimpl_o && !is_loop_branch_o && !is_rte_o
                                && (op_i[15:12] != 4'h6) && (op_i[15:7] != 9'h09D)
                                && (op_i[15:4] != 12'h4E4) && (op_i[15:2] != 14'h139D)
                                && !(op_i[5:0] inside {[6'h28:6'h3C]});
    end
endmodule // evlc_opcheck
`default_nettype wire

//--- sim/evlc_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module evlc_core_monitor
    import evlc_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        op_valid_i,
    input wire logic [15:0] disp_i,
    input wire logic        cond_true_i,
    input wire logic [15:0] loop_cnt_i,
    input wire logic        pass_done_i,
    input wire logic        irq_req_i,
    input wire logic        fault_i,
    input wire logic        loop_mode_o,
    input wire logic        fetch_en_o,
    input wire logic        loop_exit_o,
    input wire logic        exc_active_o,
    input wire logic [7:0]  vec_num_o,
    input wire logic [31:0] vec_addr_o,
    input wire logic        stopped_o,
    input wire logic        imb_shutdown_o,
    input wire logic [31:0] vbr_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence irq_quiet;
        (!irq_req_i)[*4];
    endsequence
    sequence pass_expired;
        loop_mode_o && pass_done_i && loop_cnt_i == LOOP_CNT_EXPIRED;
    endsequence
    a_loop_entry: assert property ($rose(loop_mode_o) |-> $past(op_valid_i) && $past(disp_i) == LOOP_DISP)
        else $error("loop mode entered without loop branch");
    a_fetch_quiet: assert property (loop_mode_o |-> !fetch_en_o)
        else $error("fetch enabled in loop mode");
    a_loop_stay: assert property (loop_mode_o && pass_done_i && !cond_true_i && !irq_req_i && !fault_i
        && loop_cnt_i != LOOP_CNT_EXPIRED |=> loop_mode_o)
        else $error("loop left while count and condition allow");
    a_count_exit: assert property (pass_expired |-> ##[1:2] loop_exit_o)
        else $error("no loop exit on count expiry");
    a_exc_loop_end: assert property ($rose(exc_active_o) |-> ##[0:2] !loop_mode_o)
        else $error("loop mode kept during exception");
    a_exc_fetch_back: assert property ($fell(exc_active_o) |-> ##[0:2] fetch_en_o)
        else $error("fetch not resumed after exception");
    a_vec_addr_sum: assert property (exc_active_o && $past(exc_active_o, 2) && $stable(vec_num_o)
        |-> vec_addr_o == vbr_o + {22'h0, vec_num_o, 2'h0})
        else $error("vector address not base plus four times number");
    a_stop_shut: assert property (stopped_o |-> imb_shutdown_o)
        else $error("stopped without module shutdown");
    a_stop_hold: assert property (irq_quiet ##0 stopped_o |=> stopped_o)
        else $error("stop left without interrupt");
endmodule // evlc_core_monitor
`default_nettype wire

//--- sim/evlc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module evlc_bus_model (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        iack_i,
    input  wire logic        slow_i,
    input  wire logic [7:0]  vec_sel_i,
    output logic             ack_o,
    output logic [15:0]      rdata_o,
    output logic [7:0]       vec_o,
    output logic             vec_valid_o
);
    logic [15:0] mem [logic [31:0]];
    logic [15:0] wlog [$];
    int          n_rd;
    int          wait_cnt;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            rdata_o <= 16'hA5A5;
            vec_o <= 8'h5A;
            vec_valid_o <= 1'b0;
            wait_cnt <= 0;
        end else begin
            ack_o <= 1'b0;
            vec_valid_o <= 1'b0;
            rdata_o <= ~rdata_o;
            vec_o <= ~vec_o;
            if (iack_i && !vec_valid_o) begin
                vec_valid_o <= 1'b1;
                vec_o <= vec_sel_i;
            end
            if (req_i && !ack_o) begin
                if (wait_cnt < (slow_i ? 3 : 0)) begin
                    wait_cnt <= wait_cnt + 1;
                end else begin
                    wait_cnt <= 0;
                    ack_o <= 1'b1;
                    if (we_i) begin
                        mem[addr_i] = wdata_i;
                        wlog.push_back(wdata_i);
                    end else begin
                        n_rd++;
                        rdata_o <= mem.exists(addr_i) ? mem[addr_i] : addr_i[15:0];
                    end
                end
            end
        end
    end
endmodule // evlc_bus_model
`default_nettype wire

//--- sim/exception_vector_loop_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module exception_vector_loop_control_test;
    import evlc_pkg::*;
    logic        clk_sys_i = 0, rst_n_i = 0, op_valid_i = 0, op_is_areg_i = 0, cond_true_i = 0;
    logic        pass_done_i = 0, irq_req_i = 0, irq_vec_valid_i, fault_i = 0, vbr_we_i = 0;
    logic        bus_ack_i, slow = 0, loop_mode_o, fetch_en_o, loop_exit_o, exc_active_o;
    logic        bus_req_o, bus_we_o, iack_o, restart_o, stopped_o, imb_shutdown_o, seen;
    logic [15:0] op_i = 0, disp_i = 0, loop_cnt_i = 0, sr_i = 16'h0300, bus_rdata_i, sr_o;
    logic [15:0] bus_wdata_o;
    logic [31:0] fault_state_i = 0, vbr_wdata_i = 0, pc_i = 32'h00001000, resume_pc_o;
    logic [31:0] vec_addr_o, bus_addr_o, vbr_o;
    logic [7:0]  irq_vec_i, vec_num_o, vec_sel = 8'h40;
    logic [2:0]  irq_level_i = 0, stop_level_i = 3'h3;
    evlc_size_t  size_i = EVLC_SIZE_LONG;
    int          n_mismatch = 0, samples_checked = 0, cyc_cnt = 0;
    logic [15:0] trap_ops [5] = '{16'hE8C0, 16'h06C0, 16'h0EFC, 16'hF200, 16'h8180};
    initial forever #5 clk_sys_i = ~clk_sys_i;
    evlc_core u_dut (.clk_sys_i, .rst_n_i, .op_i, .op_valid_i, .disp_i, .op_is_areg_i, .size_i,
        .cond_true_i, .loop_cnt_i, .pass_done_i, .irq_req_i, .irq_level_i, .irq_vec_i,
        .irq_vec_valid_i, .fault_i, .fault_state_i, .vbr_we_i, .vbr_wdata_i, .pc_i, .sr_i,
        .stop_level_i, .bus_ack_i, .bus_rdata_i, .loop_mode_o, .fetch_en_o, .loop_exit_o,
        .resume_pc_o, .exc_active_o, .vec_num_o, .vec_addr_o, .sr_o, .bus_req_o, .bus_we_o,
        .bus_addr_o, .bus_wdata_o, .iack_o, .restart_o, .stopped_o, .imb_shutdown_o, .vbr_o);
    evlc_bus_model u_bus (.clk_sys_i, .rst_n_i, .req_i(bus_req_o), .we_i(bus_we_o),
        .addr_i(bus_addr_o), .wdata_i(bus_wdata_o), .iack_i(iack_o), .slow_i(slow),
        .vec_sel_i(vec_sel), .ack_o(bus_ack_i), .rdata_o(bus_rdata_i), .vec_o(irq_vec_i),
        .vec_valid_o(irq_vec_valid_i));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        int k;
        k = 0;
        while (sig !== lvl && k < lim) begin cyc(1); k++; end
    endtask
    task automatic exec_op(input logic [15:0] op, input logic [15:0] disp);
        op_i = op; disp_i = disp; op_valid_i = 1'b1; cyc(1); op_valid_i = 1'b0; cyc(1);
    endtask
    task automatic pass(input logic [15:0] cnt, input logic cond);
        loop_cnt_i = cnt; cond_true_i = cond; pass_done_i = 1'b1; cyc(1); pass_done_i = 1'b0;
    endtask
    task automatic enter_loop();
        exec_op(16'h22D8, 16'h0000); exec_op(16'h51C8, LOOP_DISP); cyc(1);
    endtask
    task automatic run_exc();
        wait_for(exc_active_o, 1'b1, 60); irq_req_i = 1'b0; wait_for(exc_active_o, 1'b0, 400); cyc(3);
    endtask
    task automatic clear_log();
        u_bus.wlog.delete(); u_bus.n_rd = 0;
    endtask
    task automatic t_loop_count();
        enter_loop();
        `CHK(loop_mode_o, 1'b1)
        `CHK(fetch_en_o, 1'b0)
        pass(16'h0005, 1'b0); cyc(1);
        `CHK(loop_mode_o, 1'b1)
        pass(LOOP_CNT_EXPIRED, 1'b0); wait_for(loop_exit_o, 1'b1, 4);
        `CHK(loop_exit_o, 1'b1)
        `CHK(resume_pc_o, pc_i + 32'h4)
        cyc(1);
        `CHK({loop_mode_o, fetch_en_o}, 2'b01)
        $display("test loop_count done");
    endtask
    task automatic t_loop_refuse();
        exec_op(16'h4E75, 16'h0000); exec_op(16'h51C8, LOOP_DISP); cyc(1);
        `CHK(loop_mode_o, 1'b0)
        exec_op(16'h203C, 16'h0000); exec_op(16'h51C8, LOOP_DISP); cyc(1);
        `CHK(loop_mode_o, 1'b0)
        exec_op(16'h22D8, 16'h0000); exec_op(16'h51C8, 16'hFFFA); cyc(1);
        `CHK(loop_mode_o, 1'b0)
        enter_loop(); pass(16'h0003, 1'b1); cyc(1);
        `CHK(loop_mode_o, 1'b0)
        cond_true_i = 1'b0;
        $display("test loop_refuse done");
    endtask
    task automatic t_irq_vector();
        vbr_wdata_i = 32'h00002000; vbr_we_i = 1'b1; cyc(1); vbr_we_i = 1'b0; cyc(1);
        `CHK(vbr_o, 32'h00002000)
        slow = 1'b1; enter_loop(); clear_log();
        irq_level_i = 3'h7; irq_req_i = 1'b1; wait_for(exc_active_o, 1'b1, 60); cyc(2);
        `CHK(loop_mode_o, 1'b0)
        `CHK(sr_o & SR_SUPER_BIT, SR_SUPER_BIT)
        run_exc();
        `CHK(vec_num_o, 8'h40)
        `CHK(vec_addr_o, 32'h00002100)
        `CHK(u_bus.wlog.size(), 4)
        `CHK(u_bus.wlog[0], 16'h0300)
        `CHK({u_bus.wlog[1], u_bus.wlog[2]}, pc_i)
        `CHK(u_bus.wlog[3], {FMT_NORMAL, 12'h100})
        `CHK(u_bus.n_rd, 2)
        `CHK(fetch_en_o, 1'b1)
        slow = 1'b0;
        $display("test irq_vector done");
    endtask
    task automatic t_traps();
        for (int i = 0; i < 5; i++) begin
            clear_log(); exec_op(trap_ops[i], 16'h0000); run_exc();
            `CHK(u_bus.wlog[3], {FMT_NORMAL, 12'h02C})
        end
        $display("test traps done");
    endtask
    task automatic t_fault_rte();
        clear_log(); fault_state_i = 32'h5A5A1234; fault_i = 1'b1; cyc(1); fault_i = 1'b0; run_exc();
        `CHK(u_bus.wlog.size(), 6)
        `CHK(u_bus.wlog[3], {FMT_FAULT, 12'h008})
        `CHK({u_bus.wlog[4], u_bus.wlog[5]}, 32'h5A5A1234)
        clear_log(); seen = 1'b0; exec_op(16'h4E73, 16'h0000);
        for (int k = 0; k < 400 && !seen; k++) begin seen = (restart_o === 1'b1); cyc(1); end
        cyc(5);
        `CHK(seen, 1'b1)
        `CHK(u_bus.n_rd, 1)
        $display("test fault_rte done");
    endtask
    task automatic t_stop();
        exec_op(16'hF800, 16'h0000); wait_for(stopped_o, 1'b1, 20);
        `CHK({stopped_o, imb_shutdown_o}, 2'b11)
        irq_level_i = 3'h2; irq_req_i = 1'b1; cyc(20);
        `CHK(stopped_o, 1'b1)
        irq_level_i = 3'h5; wait_for(stopped_o, 1'b0, 20);
        `CHK(stopped_o, 1'b0)
        run_exc();
        $display("test stop done");
    endtask
    initial begin
        cyc(16);
        rst_n_i = 1'b1;
        cyc(2);
        t_loop_count();
        t_loop_refuse();
        t_irq_vector();
        t_traps();
        t_fault_rte();
        t_stop();
        complete_run();
    end
endmodule // exception_vector_loop_control_test
bind evlc_core evlc_core_monitor u_mon (.clk_sys_i, .rst_n_i, .op_valid_i, .disp_i, .cond_true_i,
    .loop_cnt_i, .pass_done_i, .irq_req_i, .fault_i, .loop_mode_o, .fetch_en_o, .loop_exit_o,
    .exc_active_o, .vec_num_o, .vec_addr_o, .stopped_o, .imb_shutdown_o, .vbr_o);
`default_nettype wire
